// file: pcm_audio_pkg.sv
`default_nettype none
package pcm_audio_pkg;
  // Sample and frame geometry.
  localparam int SAMPLE_W = 16;
  localparam int BITS_PER_FRAME = 32;
  localparam int SLOT_W = 5;
  localparam logic [4:0] SLOT_SYNC = 5'h00;
  localparam logic [4:0] SLOT_SECOND = 5'h01;
  localparam logic [4:0] SLOT_MSB = 5'h01;
  localparam logic [4:0] SLOT_LSB = 5'h10;
  localparam logic [4:0] SLOT_LONG_END = 5'h10;
  localparam logic [4:0] SLOT_RESET = 5'h1f;
  localparam logic [15:0] TX_RESET = 16'h0000;
  localparam logic [15:0] RX_RESET = 16'h0000;

  // Reference clock that feeds the link side, in Hz.
  localparam int REF_CLK_HZ = 52000000;
  // Selectable frame rates, in Hz.
  localparam int RATE_8K_HZ = 8000;
  localparam int RATE_16K_HZ = 16000;
  // Codec master clock choices, in Hz.
  localparam int MCLK_13M_HZ = 13000000;
  localparam int MCLK_26M_HZ = 26000000;

  // Reference cycles per half bit clock for each rate.
  localparam int DIV_W = 8;
  localparam logic [7:0] HALF_8K = 8'(REF_CLK_HZ / (2 * BITS_PER_FRAME * RATE_8K_HZ));
  localparam logic [7:0] HALF_16K = 8'(REF_CLK_HZ / (2 * BITS_PER_FRAME * RATE_16K_HZ));
  // Reference cycles per half master clock for each choice.
  localparam logic [1:0] MCLK_HALF_13M = 2'(REF_CLK_HZ / (2 * MCLK_13M_HZ));
  localparam logic [1:0] MCLK_HALF_26M = 2'(REF_CLK_HZ / (2 * MCLK_26M_HZ));
endpackage
`default_nettype wire

// file: sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sync_if #(parameter int W = 1);
  logic [W-1:0] d;
  logic [W-1:0] q;
  modport sync_side (input d, output q);
  modport user_side (output d, input q);
endinterface
`default_nettype wire

// file: bit_sync.sv
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  sync_if.sync_side port_if
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // Two flip-flops in series; only the second one is visible outside.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= port_if.d;
      q_r <= meta_r;
    end
  end

  assign port_if.q = q_r;
endmodule
`default_nettype wire

// file: pcm_audio_serial_master.sv
// Functional notes
// - Four wires: data out, data in, clock, sync.
// - Master only: we generate clock and sync.
// - Short-sync or long-sync framing by mode input.
// - Short sync: high 1 or 2 clocks.
// - Long sync: high 16, low 16 clocks.
// - Frame rate selectable, 8 or 16 kHz.
// - Bit clock is 32 times the frame rate.
// - Words are 16-bit mono samples each frame.
// - Two's complement, most significant bit first.
// - Codec master clock out, 13 or 26 MHz.
`timescale 1ns/100ps
`default_nettype none
module pcm_audio_serial_master (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_ref_clk_i,
  input wire logic enable_i,
  input wire logic mode_long_i,
  input wire logic sync_two_i,
  input wire logic rate_16k_i,
  input wire logic mclk_en_i,
  input wire logic mclk_26m_i,
  input wire logic [15:0] tx_sample_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [15:0] rx_sample_o,
  output logic rx_valid_o,
  output logic audio_tx_data_o,
  input wire logic audio_rx_data_i,
  output logic audio_bit_clock_o,
  output logic audio_frame_sync_out_o,
  output logic codec_master_clock_pin_o
);
  // Synchroniser carriers.
  sync_if #(.W(1)) lrst_if ();
  sync_if #(.W(7)) lin_if ();
  sync_if #(.W(1)) tgl_if ();

  // Link-side signals.
  logic link_rst_n;
  logic l_en, l_long, l_two, l_rate16, l_mclk_en, l_mclk26, l_rx;
  logic [7:0] div_r;
  logic [7:0] half;
  logic tick;
  logic bclk_r;
  logic [4:0] slot_r;
  logic [4:0] slot_nxt;
  logic fsync_r;
  logic fsync_nxt;
  logic txd_r;
  logic [15:0] tx_shift_r;
  logic [15:0] rx_shift_r;
  logic [15:0] rx_hold_r;
  logic frame_tgl_r;
  logic [1:0] mclk_cnt_r;
  logic [1:0] mclk_half;
  logic mclk_r;

  // System-side signals.
  logic [15:0] pend_r;
  logic pend_full_r;
  logic [15:0] shadow_r;
  logic tgl_seen_r;
  logic frame_evt;
  logic accept;
  logic [15:0] rx_sample_r;
  logic rx_valid_r;

  // Release of the system reset, carried into the link clock domain.
  assign lrst_if.d = rst_n_i;
  assign link_rst_n = lrst_if.q;

  bit_sync #(.W(1)) u_lrst_sync (
    .clk_i(link_ref_clk_i),
    .rst_n_i(1'b1),
    .port_if(lrst_if)
  );

  // Configuration levels and the receive pin enter the link domain here.
  assign lin_if.d = {audio_rx_data_i, mclk_26m_i, mclk_en_i, rate_16k_i, sync_two_i, mode_long_i, enable_i};
  assign {l_rx, l_mclk26, l_mclk_en, l_rate16, l_two, l_long, l_en} = lin_if.q;

  bit_sync #(.W(7)) u_link_sync (
    .clk_i(link_ref_clk_i),
    .rst_n_i(link_rst_n),
    .port_if(lin_if)
  );

  // Half-period length of the bit clock for the chosen frame rate.
  assign half = l_rate16 ? pcm_audio_pkg::HALF_16K : pcm_audio_pkg::HALF_8K;
  assign tick = (div_r == 8'(half - 8'h01));

  // Bit clock divider; the clock idles low while disabled.
  always_ff @(posedge link_ref_clk_i) begin
    if (!link_rst_n || !l_en) begin
      div_r <= 8'h00;
      bclk_r <= 1'b0;
    end else if (tick) begin
      div_r <= 8'h00;
      bclk_r <= ~bclk_r;
    end else begin
      div_r <= 8'(div_r + 8'h01);
    end
  end

  // Slot that starts at the next falling edge, and its sync level.
  assign slot_nxt = 5'(slot_r + 5'h01);

  always_comb begin
    if (l_long) begin
      fsync_nxt = (slot_nxt < pcm_audio_pkg::SLOT_LONG_END);
    end else begin
      fsync_nxt = (slot_nxt == pcm_audio_pkg::SLOT_SYNC) || (l_two && (slot_nxt == pcm_audio_pkg::SLOT_SECOND));
    end
  end

  // Frame sequencing on the falling edge: slot count, sync and transmit data.
  always_ff @(posedge link_ref_clk_i) begin
    if (!link_rst_n || !l_en) begin
      slot_r <= pcm_audio_pkg::SLOT_RESET;
      fsync_r <= 1'b0;
      txd_r <= 1'b0;
      tx_shift_r <= pcm_audio_pkg::TX_RESET;
    end else if (tick && bclk_r) begin
      slot_r <= slot_nxt;
      fsync_r <= fsync_nxt;
      if (slot_nxt == pcm_audio_pkg::SLOT_SYNC) begin
        tx_shift_r <= shadow_r;
        txd_r <= 1'b0;
      end else if (slot_nxt >= pcm_audio_pkg::SLOT_MSB && slot_nxt <= pcm_audio_pkg::SLOT_LSB) begin
        txd_r <= tx_shift_r[15];
        tx_shift_r <= {tx_shift_r[14:0], 1'b0};
      end else begin
        txd_r <= 1'b0;
      end
    end
  end

  // Receive capture on the rising edge during the sixteen data slots.
  always_ff @(posedge link_ref_clk_i) begin
    if (!link_rst_n) begin
      rx_shift_r <= pcm_audio_pkg::RX_RESET;
    end else if (l_en && tick && !bclk_r) begin
      if (slot_r >= pcm_audio_pkg::SLOT_MSB && slot_r <= pcm_audio_pkg::SLOT_LSB) begin
        rx_shift_r <= {rx_shift_r[14:0], l_rx};
      end
    end
  end

  // At each frame start the last received word is held and the system side is told.
  always_ff @(posedge link_ref_clk_i) begin
    if (!link_rst_n) begin
      rx_hold_r <= pcm_audio_pkg::RX_RESET;
      frame_tgl_r <= 1'b0;
    end else if (l_en && tick && bclk_r && (slot_nxt == pcm_audio_pkg::SLOT_SYNC)) begin
      rx_hold_r <= rx_shift_r;
      frame_tgl_r <= ~frame_tgl_r;
    end
  end

  // Codec master clock divided from the reference clock.
  assign mclk_half = l_mclk26 ? pcm_audio_pkg::MCLK_HALF_26M : pcm_audio_pkg::MCLK_HALF_13M;

  always_ff @(posedge link_ref_clk_i) begin
    if (!link_rst_n || !l_mclk_en) begin
      mclk_cnt_r <= 2'h0;
      mclk_r <= 1'b0;
    end else if (mclk_cnt_r >= 2'(mclk_half - 2'h1)) begin
      mclk_cnt_r <= 2'h0;
      mclk_r <= ~mclk_r;
    end else begin
      mclk_cnt_r <= 2'(mclk_cnt_r + 2'h1);
    end
  end

  // Pin drivers, all straight from flip-flops.
  assign audio_bit_clock_o = bclk_r;
  assign audio_frame_sync_out_o = fsync_r;
  assign audio_tx_data_o = txd_r;
  assign codec_master_clock_pin_o = mclk_r;

  // Frame toggle enters the system domain; its change marks a frame start.
  assign tgl_if.d = frame_tgl_r;

  bit_sync #(.W(1)) u_tgl_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .port_if(tgl_if)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_seen_r <= tgl_if.q;
    end
  end

  assign frame_evt = tgl_if.q ^ tgl_seen_r;
  assign tx_ready_o = !pend_full_r;
  assign accept = tx_valid_i && !pend_full_r;

  // Transmit word staging; a frame with no word sent in time carries silence.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend_r <= pcm_audio_pkg::TX_RESET;
      pend_full_r <= 1'b0;
      shadow_r <= pcm_audio_pkg::TX_RESET;
    end else if (frame_evt) begin
      if (pend_full_r) begin
        shadow_r <= pend_r;
        pend_full_r <= 1'b0;
      end else if (accept) begin
        shadow_r <= tx_sample_i;
      end else begin
        shadow_r <= pcm_audio_pkg::TX_RESET;
      end
    end else if (accept) begin
      pend_r <= tx_sample_i;
      pend_full_r <= 1'b1;
    end
  end

  // Received word handed over once per frame; the held word is stable all frame.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_sample_r <= pcm_audio_pkg::RX_RESET;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= frame_evt;
      if (frame_evt) begin
        rx_sample_r <= rx_hold_r;
      end
    end
  end

  assign rx_sample_o = rx_sample_r;
  assign rx_valid_o = rx_valid_r;
endmodule
`default_nettype wire

// file: pcm_audio_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module pcm_audio_checker (
  input wire logic link_ref_clk_i,
  input wire logic rst_n_i,
  input wire logic mode_long_i,
  input wire logic sync_two_i,
  input wire logic rate_16k_i,
  input wire logic mclk_en_i,
  input wire logic mclk_26m_i,
  input wire logic audio_tx_data_o,
  input wire logic audio_bit_clock_o,
  input wire logic audio_frame_sync_out_o,
  input wire logic codec_master_clock_pin_o
);
  logic [7:0] run_r;
  logic [4:0] slot_r;
  logic seen_r;
  logic [7:0] half;
  logic [4:0] wlast;
  // Expected half period and the last slot with sync high.
  assign half = rate_16k_i ? pcm_audio_pkg::HALF_16K : pcm_audio_pkg::HALF_8K;
  assign wlast = mode_long_i ? 5'h0f : {4'h0, sync_two_i};
  // Count reference cycles per clock level and clock falls per frame.
  always_ff @(posedge link_ref_clk_i) begin
    if (!rst_n_i) begin
      run_r <= 8'h00;
      slot_r <= 5'h00;
      seen_r <= 1'b0;
    end else begin
      run_r <= $changed(audio_bit_clock_o) ? 8'h01 : run_r + 8'h01;
      if ($fell(audio_bit_clock_o)) begin
        slot_r <= $rose(audio_frame_sync_out_o) ? 5'h00 : slot_r + 5'h01;
        seen_r <= seen_r | $rose(audio_frame_sync_out_o);
      end
    end
  end
  default clocking cb @(posedge link_ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  bit_half_a: assert property ($changed(audio_bit_clock_o) && seen_r |-> run_r == half)
    else $error("bit clock half period wrong");
  frame_len_a: assert property ($rose(audio_frame_sync_out_o) && seen_r |-> slot_r == 5'h1f)
    else $error("frame is not 32 bit clocks");
  sync_width_a: assert property ($fell(audio_frame_sync_out_o) |-> slot_r == wlast)
    else $error("sync width wrong");
  sync_edge_a: assert property ($changed(audio_frame_sync_out_o) |-> $fell(audio_bit_clock_o))
    else $error("sync moved off the falling edge");
  tx_edge_a: assert property ($changed(audio_tx_data_o) |-> $fell(audio_bit_clock_o))
    else $error("data moved off the falling edge");
  tx_idle_a: assert property ($fell(audio_bit_clock_o) && seen_r && slot_r >= 5'h10 |-> !audio_tx_data_o)
    else $error("data outside the word slots");
  mclk_fast_a: assert property ((rst_n_i && mclk_en_i && mclk_26m_i)[*8] |-> $changed(codec_master_clock_pin_o))
    else $error("fast master clock wrong");
  mclk_slow_a: assert property ((rst_n_i && mclk_en_i && !mclk_26m_i)[*8]
    |-> codec_master_clock_pin_o != $past(codec_master_clock_pin_o, 2))
    else $error("slow master clock wrong");
  mclk_off_a: assert property ((!mclk_en_i)[*4] |-> !codec_master_clock_pin_o)
    else $error("master clock runs while off");
endmodule
bind pcm_audio_serial_master pcm_audio_checker u_pcm_audio_checker (
  .link_ref_clk_i(link_ref_clk_i),
  .rst_n_i(rst_n_i),
  .mode_long_i(mode_long_i),
  .sync_two_i(sync_two_i),
  .rate_16k_i(rate_16k_i),
  .mclk_en_i(mclk_en_i),
  .mclk_26m_i(mclk_26m_i),
  .audio_tx_data_o(audio_tx_data_o),
  .audio_bit_clock_o(audio_bit_clock_o),
  .audio_frame_sync_out_o(audio_frame_sync_out_o),
  .codec_master_clock_pin_o(codec_master_clock_pin_o)
);
`default_nettype wire

// file: codec_model.sv
`timescale 1ns/100ps
`default_nettype none
module codec_model (
  input wire logic bclk_i,
  input wire logic sync_i,
  input wire logic txd_i,
  input wire logic [15:0] word_i,
  output logic rxd_o,
  output logic [15:0] got_o
);
  int slot = 0;
  logic last = 1'b0;
  logic [15:0] sh = 16'h0000;
  initial rxd_o = 1'b0;
  initial got_o = 16'h0000;
  // Track the slot on the rising edge and shift in the word, MSB first.
  always @(posedge bclk_i) begin
    slot = (sync_i && !last) ? 0 : slot + 1;
    last = sync_i;
    if (slot >= 1 && slot <= 16) sh = {sh[14:0], txd_i};
    if (slot == 17) got_o = sh;
  end
  // Drive the next slot after the fall; idle slots carry the inverse.
  always @(negedge bclk_i) begin
    if (slot < 16) rxd_o <= word_i[15 - slot];
    else rxd_o <= ~rxd_o;
  end
endmodule
`default_nettype wire

// file: pcm_audio_serial_master_bench.sv
`timescale 1ns/100ps
`default_nettype none
module pcm_audio_serial_master_bench;
  logic clk_i = 1'b0;
  logic ref_clk = 1'b0;
  logic rst_n_i = 1'b0;
  logic en = 1'b0, lng = 1'b0, two = 1'b0, r16 = 1'b0, men = 1'b0, m26 = 1'b0, tv = 1'b0;
  logic [15:0] ts = 16'h0000, cw = 16'h0000, rxs, got;
  logic rdy, rxv, txd, rxd, bclk, fs, mck;
  int mismatches = 0;
  int n_compared = 0;
  // Two unrelated clocks: system and link reference.
  initial forever #20 clk_i = ~clk_i;
  initial begin
    #3;
    forever #16 ref_clk = ~ref_clk;
  end
  pcm_audio_serial_master u_pcm_audio_serial_master (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link_ref_clk_i(ref_clk), .enable_i(en), .mode_long_i(lng), .sync_two_i(two),
    .rate_16k_i(r16), .mclk_en_i(men), .mclk_26m_i(m26), .tx_sample_i(ts), .tx_valid_i(tv),
    .tx_ready_o(rdy), .rx_sample_o(rxs), .rx_valid_o(rxv), .audio_tx_data_o(txd),
    .audio_rx_data_i(rxd), .audio_bit_clock_o(bclk), .audio_frame_sync_out_o(fs),
    .codec_master_clock_pin_o(mck));
  codec_model u_codec_model (.bclk_i(bclk), .sync_i(fs), .txd_i(txd), .word_i(cw), .rxd_o(rxd), .got_o(got));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Wait, bounded, for the next receive pulse.
  task automatic wait_rx;
    int i;
    for (i = 0; i < 6000; i++) begin
      @(negedge clk_i);
      if (rxv === 1'b1) break;
    end
    if (i == 6000) begin
      mismatches++;
      print_verdict;
    end
  endtask
  // Reset into a framing setup, wait for four receive pulses (three whole frames), then check both words.
  task automatic phase(input logic [4:0] c, input logic v, input logic [15:0] w);
    rst_n_i = 1'b0;
    en = 1'b0;
    {lng, two, r16, men, m26} = c;
    tv = v;
    ts = w;
    cw = ~w;
    repeat (20) @(negedge clk_i);
    chk("idle pins", {10'h000, mck, rdy, rxv, bclk, fs, txd}, 16'h0010);
    rst_n_i = 1'b1;
    en = 1'b1;
    // A word offered at release is staged at once, so ready drops until the first frame event.
    repeat (2) @(negedge clk_i);
    chk("tx ready", {15'h0000, rdy}, {15'h0000, !v});
    repeat (4) wait_rx;
    chk("codec word", got, v ? w : 16'h0000);
    chk("rx word", rxs, ~w);
    $display("test %b done", c);
  endtask
  initial begin
    phase(5'b00111, 1'b1, 16'h8001);
    phase(5'b01110, 1'b1, 16'h7ffe);
    phase(5'b10000, 1'b1, 16'hc3a5);
    phase(5'b10101, 1'b0, 16'h1234);
    print_verdict;
  end
endmodule
`default_nettype wire
